// >>> inc/adsp_if.sv
// serial link between the converter device and its host
// open-drain lines modelled with pull-ups: a line is low while its enable is high
`timescale 1ns/1ps
`default_nettype none
interface adsp_if;
  logic receive_clock_out_o;
  logic receive_clock_out_oe;
  logic receive_frame_n_o;
  logic receive_frame_n_oe;
  logic receive_data_out_o;
  logic receive_data_out_oe;
  logic receive_clock_out;
  logic receive_frame_n;
  logic receive_data_out;
  logic transmit_clock_in;
  logic transmit_frame_n;
  logic transmit_data_in;
  logic convert_start_n;
  logic dac_load_n;

  // pull-up resolution of the open-drain trio
  assign receive_clock_out = receive_clock_out_oe ? receive_clock_out_o : 1'b1;
  assign receive_frame_n = receive_frame_n_oe ? receive_frame_n_o : 1'b1;
  assign receive_data_out = receive_data_out_oe ? receive_data_out_o : 1'b1;

  modport device (
    output receive_clock_out_o, receive_clock_out_oe,
    output receive_frame_n_o, receive_frame_n_oe,
    output receive_data_out_o, receive_data_out_oe,
    input receive_clock_out, receive_frame_n, receive_data_out,
    input transmit_clock_in, transmit_frame_n, transmit_data_in,
    input convert_start_n, dac_load_n
  );
  modport host (
    input receive_clock_out, receive_frame_n, receive_data_out,
    output transmit_clock_in, transmit_frame_n, transmit_data_in,
    output convert_start_n, dac_load_n
  );
endinterface
`default_nettype wire

// >>> inc/adsp_params.svh
// constants for the adc/dac serial port control ends
// assumes a 250 MHz system clock shared by both ends
`ifndef ADSP_PARAMS_SVH
`define ADSP_PARAMS_SVH

`define ADSP_SYS_CLK_NS 4
`define ADSP_ADC_CLK_NS 500
`define ADSP_ADC_HALF_CYC (`ADSP_ADC_CLK_NS / (2 * `ADSP_SYS_CLK_NS))
`define ADSP_LATE_NS 30
`define ADSP_LATE_CYC (`ADSP_LATE_NS / `ADSP_SYS_CLK_NS)
`define ADSP_CONV_EDGES 5'h13
`define ADSP_CONV_EDGES_LATE 5'h14
`define ADSP_WORD_BITS 5'h10
`define ADSP_LAST_BIT 5'h0F
`define ADSP_DAC_OFFSET 14'h2000
`define ADSP_TRANSMIT_CLOCK_IN_NS 500
`define ADSP_TRANSMIT_CLOCK_IN_HALF_CYC (`ADSP_TRANSMIT_CLOCK_IN_NS / (2 * `ADSP_SYS_CLK_NS))
`define ADSP_STROBE_NS 100
`define ADSP_STROBE_CYC ((`ADSP_STROBE_NS + `ADSP_SYS_CLK_NS - 1) / `ADSP_SYS_CLK_NS)
`define ADSP_FIFO_DEPTH 32
`define ADSP_FIFO_WIDTH 16

`endif

// >>> inc/adsp_pkg.sv
// types shared by both ends of the converter serial port
// assumes adsp_params.svh sits on the include path
`default_nettype none
package adsp_pkg;
  typedef enum logic [0:0] {CONV_IDLE, CONV_RUN} adsp_conv_e;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_GAP} adsp_tx_e;
  typedef logic [13:0] adsp_code_t;
endpackage
`default_nettype wire

// >>> rtl/adsp_device.sv
// device end: adc conversion control with serial result output, dac serial input
// assumes link pins synchronous to sys_clk except convert_start_n, which is synchronised
// Summary of operation
// RL1: analog output changes only on dac latch update
// RL2: codes are 14-bit two's complement, fs/16384
// RL3: 2000h most negative, 1fffh most positive
// RL4: convert_start_n rising starts conversion, enters hold
// RL5: serial result shifts out during conversion
// RL6: word is two zeros then 14-bit msb-first
// RL7: data changes on rising clock, sampled falling
// RL8: frame low at start, first zero on first fall
// RL9: receive clock, frame, data are open-drain
// RL10: receive clock derived from adc master clock
// RL11: clock mode selects stopping or continuous receive clock
// RL12: input latch separate; dac latch alone drives output
// RL13: host sends 16-bit words sampled on falling edges
// RL14: after frame falls, accept next 16 falls
// RL15: drop first two bits, keep 14 msb-first
// RL16: load held low updates on sixteenth fall
// RL17: load falling mid-transfer defers to sixteenth fall
// RL18: load returning high mid-transfer cancels update
// RL19: host may time convert and load freely
// RL20: host raises transmit frame between words
// RL21: convert start synchronised inside the device
// RL22: conversion takes 19 or 20 rising edges
// RL23: transmit frame fall restarts the bit count
`timescale 1ns/1ps
`default_nettype none
`include "adsp_params.svh"
module adsp_device import adsp_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  adsp_if.device link,
  input wire logic [13:0] adc_sample,
  input wire logic clk_continuous,
  output logic track_hold,
  output logic [13:0] dac_code,
  output logic [13:0] dac_level
);
  // synchroniser state
  logic cs_meta, cs_sync, cs_prev;
  // adc group
  adsp_conv_e state, next_state;
  logic [6:0] half_cnt, next_half_cnt;
  logic adc_lvl, next_adc_lvl;
  logic [4:0] rise_cnt, next_rise_cnt;
  logic [4:0] edges_needed, next_edges_needed;
  logic [15:0] res_shift, next_res_shift;
  logic frame, next_frame;
  logic next_track_hold;
  logic rclk_oe, next_rclk_oe;
  logic frame_oe, next_frame_oe;
  logic data_oe, next_data_oe;
  logic run, tick, rise, start, next_run;
  // dac group
  logic tx_clk_prev, next_tx_clk_prev;
  logic tx_frame_prev, next_tx_frame_prev;
  logic ld_prev, next_ld_prev;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic loading, next_loading;
  logic [15:0] in_shift, next_in_shift;
  adsp_code_t in_latch, next_in_latch;
  adsp_code_t next_dac_code, next_dac_level;
  logic tfall, tx_frame_fall, ld_fall, busy;

  // open-drain pins only ever pull low
  assign link.receive_clock_out_o = 1'b0; // [RL9]
  assign link.receive_frame_n_o = 1'b0;
  assign link.receive_data_out_o = 1'b0;
  assign link.receive_clock_out_oe = rclk_oe;
  assign link.receive_frame_n_oe = frame_oe;
  assign link.receive_data_out_oe = data_oe;

  // two-stage synchroniser, edge taken from the second stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= link.convert_start_n; // [RL21]
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  // adc clock divider, conversion sequence and result shifter
  always_comb begin
    next_state = state;
    next_half_cnt = half_cnt;
    next_adc_lvl = adc_lvl;
    next_rise_cnt = rise_cnt;
    next_edges_needed = edges_needed;
    next_res_shift = res_shift;
    next_frame = frame;
    next_track_hold = track_hold;
    run = clk_continuous || (state == CONV_RUN);
    tick = (half_cnt == 7'(`ADSP_ADC_HALF_CYC - 1));
    rise = run && tick && !adc_lvl;
    start = cs_sync && !cs_prev; // [RL4]
    // master clock: receive clock follows it directly
    if (run) begin // [RL10]
      if (tick) begin
        next_half_cnt = 7'h00;
        next_adc_lvl = !adc_lvl;
      end else begin
        next_half_cnt = half_cnt + 7'h01;
      end
    end else begin
      next_half_cnt = 7'h00;
      next_adc_lvl = 1'b0;
    end
    unique case (state)
      CONV_IDLE: begin
        if (start) begin
          next_state = CONV_RUN;
          next_track_hold = 1'b1; // [RL4]
          next_res_shift = {2'b00, adc_sample}; // [RL6] [RL2]
          next_frame = 1'b1; // [RL8]
          next_rise_cnt = 5'h00;
          // clock high or released: first edge in the frame is a fall, one count pre-taken
          if (!clk_continuous || adc_lvl || tick) begin
            next_rise_cnt = 5'h01; // [RL8]
          end
          // a pre-taken count, or a start just before a rising edge, needs one more
          if (!clk_continuous || adc_lvl ||
              half_cnt >= 7'(`ADSP_ADC_HALF_CYC - `ADSP_LATE_CYC)) begin
            next_edges_needed = `ADSP_CONV_EDGES_LATE; // [RL22]
          end else begin
            next_edges_needed = `ADSP_CONV_EDGES; // [RL22]
          end
          if (!clk_continuous) begin
            next_half_cnt = 7'h00;
            next_adc_lvl = 1'b0;
          end
        end
      end
      CONV_RUN: begin
        if (rise) begin
          next_rise_cnt = rise_cnt + 5'h01;
          // bit changes on rising edge, while conversion runs
          if (rise_cnt != 5'h00 && rise_cnt < `ADSP_WORD_BITS) begin
            next_res_shift = {res_shift[14:0], 1'b0}; // [RL7] [RL5]
          end
          if (rise_cnt == `ADSP_WORD_BITS) begin
            next_frame = 1'b0;
          end
          if (next_rise_cnt == edges_needed) begin
            next_state = CONV_IDLE;
            next_track_hold = 1'b0;
            next_frame = 1'b0;
            if (!clk_continuous) begin
              next_half_cnt = 7'h00;
              next_adc_lvl = 1'b0; // [RL11]
            end
          end
        end
      end
    endcase
    next_run = clk_continuous || (next_state == CONV_RUN);
    // noncontinuous clock releases to three-state when idle
    next_rclk_oe = next_run && !next_adc_lvl; // [RL11] [RL9]
    next_frame_oe = next_frame; // [RL8]
    next_data_oe = next_frame && !next_res_shift[15]; // [RL9]
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= CONV_IDLE;
      half_cnt <= 7'h00;
      adc_lvl <= 1'b0;
      rise_cnt <= 5'h00;
      edges_needed <= `ADSP_CONV_EDGES;
      res_shift <= 16'h0000;
      frame <= 1'b0;
      track_hold <= 1'b0;
      rclk_oe <= 1'b0;
      frame_oe <= 1'b0;
      data_oe <= 1'b0;
    end else begin
      state <= next_state;
      half_cnt <= next_half_cnt;
      adc_lvl <= next_adc_lvl;
      rise_cnt <= next_rise_cnt;
      edges_needed <= next_edges_needed;
      res_shift <= next_res_shift;
      frame <= next_frame;
      track_hold <= next_track_hold;
      rclk_oe <= next_rclk_oe;
      frame_oe <= next_frame_oe;
      data_oe <= next_data_oe;
    end
  end

  // dac input latch and dac latch update control
  always_comb begin
    next_tx_clk_prev = link.transmit_clock_in;
    next_tx_frame_prev = link.transmit_frame_n;
    next_ld_prev = link.dac_load_n;
    next_in_shift = in_shift;
    next_in_latch = in_latch;
    next_dac_code = dac_code;
    tfall = tx_clk_prev && !link.transmit_clock_in;
    tx_frame_fall = tx_frame_prev && !link.transmit_frame_n;
    ld_fall = ld_prev && !link.dac_load_n;
    busy = loading || tx_frame_fall;
    next_loading = busy;
    next_bit_cnt = tx_frame_fall ? 5'h00 : bit_cnt; // [RL23]
    // falling edges sampled only while frame is low
    if (tfall && busy && !link.transmit_frame_n) begin // [RL13] [RL14]
      next_in_shift = {in_shift[14:0], link.transmit_data_in};
      next_bit_cnt = next_bit_cnt + 5'h01;
      if (next_bit_cnt == `ADSP_WORD_BITS) begin
        next_in_latch = next_in_shift[13:0]; // [RL15]
        next_loading = 1'b0;
        next_bit_cnt = 5'h00;
        // load low at the sixteenth fall: update now
        if (!link.dac_load_n) begin
          next_dac_code = next_in_shift[13:0]; // [RL16] [RL17] [RL18]
        end
      end
    end
    // load falling edge outside a transfer moves the input latch
    if (ld_fall && !busy) begin // [RL17]
      next_dac_code = in_latch; // [RL1] [RL12]
    end
    // offset binary level: 2000h lowest, 0000h mid, 1fffh highest
    next_dac_level = next_dac_code ^ `ADSP_DAC_OFFSET; // [RL3] [RL2]
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_clk_prev <= 1'b1;
      tx_frame_prev <= 1'b1;
      ld_prev <= 1'b1;
      bit_cnt <= 5'h00;
      loading <= 1'b0;
      in_shift <= 16'h0000;
      in_latch <= 14'h0000;
      dac_code <= 14'h0000;
      dac_level <= `ADSP_DAC_OFFSET;
    end else begin
      tx_clk_prev <= next_tx_clk_prev;
      tx_frame_prev <= next_tx_frame_prev;
      ld_prev <= next_ld_prev;
      bit_cnt <= next_bit_cnt;
      loading <= next_loading;
      in_shift <= next_in_shift;
      in_latch <= next_in_latch;
      dac_code <= next_dac_code;
      dac_level <= next_dac_level;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/adsp_host.sv
// host end: word fifo, transmit framing, convert and load strobes, result capture
// assumes the device end on the same sys_clk through adsp_if
`timescale 1ns/1ps
`default_nettype none
`include "adsp_params.svh"
module adsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  // pointer and occupancy update
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? AW'((32'(wr_ptr) + 1) % DEPTH) : wr_ptr;
    next_rd_ptr = pop ? AW'((32'(rd_ptr) + 1) % DEPTH) : rd_ptr;
    next_count = CW'(32'(count) + 32'(push) - 32'(pop));
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= (32'(next_count) != DEPTH);
      out_valid <= (next_count != '0);
    end
  end

  // storage has no reset
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_data = mem[rd_ptr];
endmodule

module adsp_host import adsp_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  adsp_if.host link,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [15:0] word_data,
  input wire logic conv_req,
  input wire logic load_auto,
  output logic rx_valid,
  output logic [13:0] rx_data
);
  logic fifo_valid, fifo_pop;
  logic [15:0] fifo_data;
  adsp_tx_e state, next_state;
  logic [6:0] half_cnt, next_half_cnt;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [15:0] tx_shift, next_tx_shift;
  logic tx_clk, next_tx_clk, tx_frame_n, next_tx_frame_n, tdat, next_tdat;
  logic ld_n, next_ld_n, cs_n, next_cs_n;
  logic [6:0] cs_cnt, next_cs_cnt;
  logic rclk_prev, rx_frame_prev;
  logic [4:0] rx_cnt, next_rx_cnt;
  logic [15:0] rx_shift, next_rx_shift;
  logic next_rx_valid;
  logic [13:0] next_rx_data;
  logic tick;

  adsp_fifo #(.WIDTH(`ADSP_FIFO_WIDTH), .DEPTH(`ADSP_FIFO_DEPTH)) adsp_fifo_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .in_data(word_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign link.transmit_clock_in = tx_clk;
  assign link.transmit_frame_n = tx_frame_n;
  assign link.transmit_data_in = tdat;
  assign link.dac_load_n = ld_n;
  assign link.convert_start_n = cs_n;

  // transmit word sequencer, load and convert strobes
  always_comb begin
    next_state = state;
    next_half_cnt = half_cnt + 7'h01;
    next_bit_cnt = bit_cnt;
    next_tx_shift = tx_shift;
    next_tx_clk = tx_clk;
    next_tx_frame_n = tx_frame_n;
    next_tdat = tdat;
    next_ld_n = !load_auto; // [RL16]
    fifo_pop = 1'b0;
    tick = (half_cnt == 7'(`ADSP_TRANSMIT_CLOCK_IN_HALF_CYC - 1));
    unique case (state)
      TX_IDLE: begin
        next_half_cnt = 7'h00;
        if (fifo_valid) begin
          fifo_pop = 1'b1;
          next_state = TX_SHIFT;
          next_tx_shift = fifo_data;
          next_tx_frame_n = 1'b0;
          next_tdat = fifo_data[15]; // [RL13]
          next_bit_cnt = 5'h00;
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          next_half_cnt = 7'h00;
          next_tx_clk = !tx_clk;
          if (tx_clk) begin
            next_bit_cnt = bit_cnt + 5'h01; // [RL14]
          end else if (bit_cnt == `ADSP_WORD_BITS) begin
            next_tx_frame_n = 1'b1; // [RL20]
            next_state = TX_GAP;
          end else begin
            next_tx_shift = {tx_shift[14:0], 1'b0};
            next_tdat = tx_shift[14];
          end
        end
      end
      TX_GAP: begin
        // load pulse after the word when not held low
        if (!load_auto && half_cnt < 7'(`ADSP_STROBE_CYC)) begin
          next_ld_n = 1'b0; // [RL19]
        end
        if (tick) begin
          next_state = TX_IDLE;
        end
      end
      default: begin
        next_state = TX_IDLE;
      end
    endcase
    // convert strobe: low for a while, rising edge starts conversion
    next_cs_cnt = cs_cnt;
    next_cs_n = cs_n;
    if (conv_req && cs_n) begin
      next_cs_n = 1'b0;
      next_cs_cnt = 7'h00;
    end else if (!cs_n) begin
      next_cs_cnt = cs_cnt + 7'h01;
      if (cs_cnt == 7'(`ADSP_STROBE_CYC - 1)) begin
        next_cs_n = 1'b1; // [RL19]
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= TX_IDLE;
      half_cnt <= 7'h00;
      bit_cnt <= 5'h00;
      tx_shift <= 16'h0000;
      tx_clk <= 1'b1;
      tx_frame_n <= 1'b1;
      tdat <= 1'b0;
      ld_n <= 1'b1;
      cs_n <= 1'b1;
      cs_cnt <= 7'h00;
    end else begin
      state <= next_state;
      half_cnt <= next_half_cnt;
      bit_cnt <= next_bit_cnt;
      tx_shift <= next_tx_shift;
      tx_clk <= next_tx_clk;
      tx_frame_n <= next_tx_frame_n;
      tdat <= next_tdat;
      ld_n <= next_ld_n;
      cs_n <= next_cs_n;
      cs_cnt <= next_cs_cnt;
    end
  end

  // result capture on receive clock falling edges while frame is low
  always_comb begin
    next_rx_cnt = (rx_frame_prev && !link.receive_frame_n) ? 5'h00 : rx_cnt;
    next_rx_shift = rx_shift;
    next_rx_valid = 1'b0;
    next_rx_data = rx_data;
    if (rclk_prev && !link.receive_clock_out && !link.receive_frame_n) begin
      next_rx_shift = {rx_shift[14:0], link.receive_data_out}; // [RL2]
      next_rx_cnt = next_rx_cnt + 5'h01;
      if (next_rx_cnt == `ADSP_WORD_BITS) begin
        next_rx_valid = 1'b1;
        next_rx_data = next_rx_shift[13:0];
        next_rx_cnt = 5'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rclk_prev <= 1'b1;
      rx_frame_prev <= 1'b1;
      rx_cnt <= 5'h00;
      rx_shift <= 16'h0000;
      rx_valid <= 1'b0;
      rx_data <= 14'h0000;
    end else begin
      rclk_prev <= link.receive_clock_out;
      rx_frame_prev <= link.receive_frame_n;
      rx_cnt <= next_rx_cnt;
      rx_shift <= next_rx_shift;
      rx_valid <= next_rx_valid;
      rx_data <= next_rx_data;
    end
  end
endmodule
`default_nettype wire

// >>> test/adc_dac_serial_port_control_tb.sv
// self-checking bench: host and device ends joined over the serial link
// assumes sys_clk at 250 MHz; every long wait is bounded and ends in summarize
`timescale 1ns/1ps
`default_nettype none
module adc_dac_serial_port_control_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_continuous = 1'b0;
  logic word_valid = 1'b0;
  logic conv_req = 1'b0;
  logic load_auto = 1'b1;
  logic [13:0] adc_sample = 14'h0000;
  logic [15:0] word_data = 16'h0000;
  logic track_hold, word_ready, rx_valid, r;
  logic [13:0] dac_code, dac_level, rx_data, c, p;
  logic [13:0] samples [4] = '{14'h2000, 14'h1fff, 14'h0000, 14'h2aaa};
  int mismatches = 0;
  int num_checks = 0;
  int n, k, h;

  adsp_if link_if ();
  adsp_device adsp_device_inst (.sys_clk(sys_clk), .rst(rst), .link(link_if),
    .adc_sample(adc_sample), .clk_continuous(clk_continuous), .track_hold(track_hold),
    .dac_code(dac_code), .dac_level(dac_level));
  adsp_host adsp_host_inst (.sys_clk(sys_clk), .rst(rst), .link(link_if),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
    .conv_req(conv_req), .load_auto(load_auto), .rx_valid(rx_valid), .rx_data(rx_data));
  adsp_link_monitor adsp_link_monitor_inst (.sys_clk(sys_clk), .rst(rst),
    .receive_clock_out_o(link_if.receive_clock_out_o),
    .receive_frame_n_o(link_if.receive_frame_n_o),
    .receive_data_out_o(link_if.receive_data_out_o),
    .receive_clock_out(link_if.receive_clock_out), .receive_frame_n(link_if.receive_frame_n),
    .receive_data_out(link_if.receive_data_out), .transmit_clock_in(link_if.transmit_clock_in),
    .transmit_frame_n(link_if.transmit_frame_n), .transmit_data_in(link_if.transmit_data_in),
    .convert_start_n(link_if.convert_start_n));

  // system clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [13:0] code_of(input int i);
    if (i == 0) return 14'h1fff;
    if (i == 1) return 14'h2000;
    if (i == 2) return 14'h0000;
    return 14'(i * 291);
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input int cnt);
    repeat (cnt) @(posedge sys_clk);
  endtask

  // bounded wait for the transmit frame to reach a level
  task automatic wait_frame(input logic lvl);
    k = 0;
    while (link_if.transmit_frame_n !== lvl && k < 4000) begin
      @(negedge sys_clk);
      k++;
    end
    check(16'(k < 4000), 16'h0001);
  endtask

  // main sequence
  initial begin
    tick(4);
    rst <= 1'b0;
    @(negedge sys_clk);
    check({2'b00, dac_code}, 16'h0000);
    check({2'b00, dac_level}, 16'h2000);
    check({13'h0000, track_hold, word_ready, rx_valid}, 16'h0002);
    check({13'h0000, link_if.receive_clock_out, link_if.receive_frame_n,
      link_if.receive_data_out}, 16'h0007);
    // fill the word fifo until it refuses, stalled by the slow link
    @(posedge sys_clk);
    word_valid <= 1'b1;
    word_data <= {2'b10, code_of(0)};
    n = 0;
    forever begin
      @(negedge sys_clk);
      if (word_ready !== 1'b1) break;
      @(posedge sys_clk);
      n++;
      word_data <= {2'(n) ^ 2'b10, code_of(n)};
    end
    @(posedge sys_clk);
    word_valid <= 1'b0;
    check(16'(n >= 32 && n <= 33), 16'h0001);
    // drain: every word reaches the dac latch in order, top two bits dropped
    p = 14'h0000;
    for (int i = 0; i < n; i++) begin
      c = code_of(i);
      k = 0;
      while (dac_code === p && k < 3000) begin
        @(negedge sys_clk);
        k++;
      end
      check({2'b00, dac_code}, {2'b00, c});
      check({2'b00, dac_level}, {2'b00, ~c[13], c[12:0]});
      p = c;
    end
    check({15'h0000, word_ready}, 16'h0001);
    // load strobe falling mid-word: deferred, and cancelled if it returns high
    @(posedge sys_clk);
    load_auto <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      c = 14'h0aaa ^ {14{i[0]}};
      tick(200);
      word_valid <= 1'b1;
      word_data <= {2'b01, c};
      tick(1);
      word_valid <= 1'b0;
      wait_frame(1'b0);
      tick(1000);
      load_auto <= 1'b1;
      tick(100);
      check({2'b00, dac_code}, {2'b00, p});
      if (i == 0) begin
        tick(300);
        load_auto <= 1'b0;
      end
      wait_frame(1'b1);
      check({2'b00, dac_code}, {2'b00, (i == 0) ? p : c});
      tick(40);
      check({2'b00, dac_code}, {2'b00, c});
      p = c;
    end
    // conversions in both receive clock modes, one result per start
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      adc_sample <= samples[i];
      clk_continuous <= i[0];
      conv_req <= 1'b1;
      @(posedge sys_clk);
      conv_req <= 1'b0;
      k = 0;
      while (track_hold !== 1'b1 && k < 100) begin
        @(negedge sys_clk);
        k++;
      end
      check(16'(k < 100), 16'h0001);
      h = 0;
      n = 0;
      while (track_hold === 1'b1 && h < 3000) begin
        @(negedge sys_clk);
        h++;
        if (rx_valid === 1'b1) n++;
      end
      check(16'(n), 16'h0001);
      check({2'b00, rx_data}, {2'b00, samples[i]});
      if (i[0]) check(16'(h >= 2200 && h <= 2500), 16'h0001);
      else check(16'(h >= 2280 && h <= 2310), 16'h0001);
      // receive clock after the end: still toggling only in continuous mode
      h = 0;
      r = link_if.receive_clock_out;
      repeat (300) begin
        @(negedge sys_clk);
        if (link_if.receive_clock_out !== r) h++;
        r = link_if.receive_clock_out;
      end
      check(16'(h > 0), 16'(i[0]));
    end
    summarize();
  end

  // watchdog against a hung handshake, tests need about 83000 cycles
  initial begin
    tick(95000);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire

// >>> test/adsp_link_monitor.sv
// concurrent checks on the converter serial link between host and device ends
// assumes both ends share sys_clk; receive lines are the pulled-up resolved levels
`timescale 1ns/1ps
`default_nettype none
module adsp_link_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic receive_clock_out_o,
  input wire logic receive_frame_n_o,
  input wire logic receive_data_out_o,
  input wire logic receive_clock_out,
  input wire logic receive_frame_n,
  input wire logic receive_data_out,
  input wire logic transmit_clock_in,
  input wire logic transmit_frame_n,
  input wire logic transmit_data_in,
  input wire logic convert_start_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic [4:0] rx_falls;
  logic [4:0] next_rx_falls;
  logic [4:0] tx_falls;
  logic [4:0] next_tx_falls;
  logic prev_rclk;
  logic prev_tx_clk;

  // falling clock edges counted while each frame is low
  always_comb begin
    next_rx_falls = receive_frame_n ? 5'h00 : rx_falls + 5'(prev_rclk & ~receive_clock_out);
    next_tx_falls = transmit_frame_n ? 5'h00 : tx_falls + 5'(prev_tx_clk & ~transmit_clock_in);
  end

  // counter and previous clock levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_falls <= 5'h00;
      tx_falls <= 5'h00;
      prev_rclk <= 1'b1;
      prev_tx_clk <= 1'b1;
    end else begin
      rx_falls <= next_rx_falls;
      tx_falls <= next_tx_falls;
      prev_rclk <= receive_clock_out;
      prev_tx_clk <= transmit_clock_in;
    end
  end

  a_od_low_only: assert property (!(receive_clock_out_o | receive_frame_n_o | receive_data_out_o))
    else $error("open-drain value not low");
  a_rx_word_len: assert property ($rose(receive_frame_n) |-> rx_falls == 5'h10)
    else $error("receive frame not 16 falls long");
  a_rx_lead_zero: assert property (!receive_frame_n && rx_falls < 5'h02 |-> !receive_data_out)
    else $error("leading bits not zero");
  a_rx_data_rise: assert property ($changed(receive_data_out) && !receive_frame_n &&
    $past(!receive_frame_n) |-> $rose(receive_clock_out))
    else $error("receive data moved off a rising clock");
  a_conv_frame_start: assert property ($rose(convert_start_n) && receive_frame_n |->
    ##[2:6] !receive_frame_n)
    else $error("frame did not fall after start");
  a_rclk_half_stable: assert property ($changed(receive_clock_out) && !receive_frame_n |=>
    $stable(receive_clock_out) [*8])
    else $error("receive clock half period too short");
  a_tx_word_len: assert property ($rose(transmit_frame_n) |-> tx_falls == 5'h10)
    else $error("transmit frame not 16 falls long");
  a_tx_frame_gap: assert property (tx_falls <= 5'h10)
    else $error("transmit frame held past one word");
  a_tx_data_rise: assert property ($changed(transmit_data_in) && !transmit_frame_n &&
    $past(!transmit_frame_n) |-> $rose(transmit_clock_in))
    else $error("transmit data moved off a rising clock");
endmodule
`default_nettype wire
